//--- logic/mcs_angle_filter.sv
// First-order angle filter with end-stop hysteresis bypass.
`include "mcs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mcs_angle_filter #(
  parameter int POS_W = `MCS_POS_W,
  parameter int SHIFT = `MCS_FILT_SHIFT
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic sample_in,
  input wire logic restart_in,
  input wire logic enable_in,
  input wire logic [POS_W-1:0] pos_in,
  output logic [POS_W-1:0] pos_out
);
  logic bypass_r;
  logic bypass_nxt;
  logic signed [POS_W:0] diff;
  logic signed [POS_W:0] step;

  // The difference is one bit wider so it cannot overflow.
  assign diff = $signed({pos_in[POS_W-1], pos_in}) -
                $signed({pos_out[POS_W-1], pos_out});
  assign step = diff >>> SHIFT;

  // Hysteresis keeps the filter off near the end stops, where wrapping would
  // smear across a turn boundary.
  always_comb begin
    bypass_nxt = bypass_r;
    if ($signed(pos_in) > $signed(`MCS_HI_OFF)) begin
      bypass_nxt = 1'b1;
    end else if ($signed(pos_in) < $signed(`MCS_LO_OFF)) begin
      bypass_nxt = 1'b1;
    end else if ($signed(pos_in) < $signed(`MCS_HI_ON) &&
                 $signed(pos_in) > $signed(`MCS_LO_ON)) begin
      bypass_nxt = 1'b0;
    end
  end

  // Bypass state follows samples only.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      bypass_r <= 1'b0;
    end else if (sample_in) begin
      bypass_r <= bypass_nxt;
    end
  end

  // Bypassed or disabled samples also load the state for a clean resume.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pos_out <= '0;
    end else if (sample_in) begin
      if (restart_in || !enable_in || bypass_nxt) begin
        pos_out <= pos_in;
      end else begin
        pos_out <= pos_out + step[POS_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/mcs_conv_seq.sv
// Conversion sequencer: modes, triggers, busy and position post-processing.
`include "mcs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mcs_conv_seq #(
  parameter int ANG_PER_SEQ = `MCS_ANG_PER_SEQ
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [`MCS_ADDR_W-1:0] addr_in,
  input wire logic [`MCS_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`MCS_DATA_W-1:0] rdata_out,
  input wire logic convert_start_pin_in,
  input wire mcs_pkg::mcs_meas_type tsens_res_in,
  input wire mcs_pkg::mcs_meas_type angle_res_in,
  output logic tsens_req_out,
  output logic angle_req_out,
  output logic busy_out,
  output logic angle_calc_active_out
);
  import mcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  mcs_state_type state_r;
  mcs_state_type state_nxt;
  logic [1:0] convert_field_r;
  logic [`MCS_PAGE_W-1:0] page_r;
  logic conversion_mode_select_r;
  logic angle_filter_enable_r;
  logic synced_angle_trigger_r;
  logic [1:0] pin_function_enable_r;
  logic xchk_fault_r;
  logic [`MCS_ANGLE_W-1:0] angle_reg_r;
  logic [`MCS_TURN_W-1:0] turn_reg_r;
  logic turn_valid_r;
  logic boot_start_r;
  logic pin_prev_r;
  logic first_seq_r;
  logic load_ref_r;
  logic filt_restart_r;
  logic [5:0] tsens_turn_r;
  logic [7:0] ang_cnt_r;
  logic cnv_pin_en;
  logic pin_fall;
  logic pin_rise;
  logic cnv_write;
  logic start_ev;
  logic abort_ev;
  logic seq_last;
  logic xchk_hit;
  mcs_pos_type track_pos;
  logic [`MCS_POS_W-1:0] filt_pos;
  mcs_pos_type filt_view;

  // Absolute distance of two positions, in fractions of a turn.
  function automatic logic [`MCS_POS_W-1:0] pos_dist(
    input logic [`MCS_POS_W-1:0] a,
    input logic [`MCS_POS_W-1:0] b
  );
    logic [`MCS_POS_W-1:0] d;
    d = a - b;
    if (d[`MCS_POS_W-1]) begin
      d = b - a;
    end
    return d;
  endfunction

  // Register-port decode; used by both the write and the read side.
  function automatic logic hit(
    input logic [`MCS_ADDR_W-1:0] a,
    input logic [`MCS_ADDR_W-1:0] off
  );
    return a == off;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Trigger events from the pin and the convert field.

  // The pin only acts once software has given it the convert function.
  assign cnv_pin_en = pin_function_enable_r[`MCS_PIN_CNV_BIT];
  assign pin_fall = cnv_pin_en && pin_prev_r && !convert_start_pin_in;
  assign pin_rise = cnv_pin_en && !pin_prev_r && convert_start_pin_in;

  assign cnv_write = wr_in && hit(addr_in, `MCS_ADDR_CNV) && !cnv_pin_en;

  assign start_ev = pin_fall ||
    (cnv_write && wdata_in[`MCS_CNV_HI:`MCS_CNV_LO] == `MCS_CNV_START);
  assign abort_ev = pin_rise ||
    (cnv_write && wdata_in[`MCS_CNV_HI:`MCS_CNV_LO] == `MCS_CNV_ABORT);

  // Previous pin level for edge detection; the pin is already synchronous.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= convert_start_pin_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      boot_start_r <= 1'b1;
    end else begin
      boot_start_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software-written registers.

  // Convert and page field; the convert bits keep their last accepted value.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      convert_field_r <= 2'h0;
      page_r <= '0;
    end else if (wr_in && hit(addr_in, `MCS_ADDR_CNV)) begin
      page_r <= wdata_in[`MCS_PAGE_W-1:0];
      if (!cnv_pin_en) begin
        convert_field_r <= wdata_in[`MCS_CNV_HI:`MCS_CNV_LO];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      conversion_mode_select_r <= 1'b0;
      angle_filter_enable_r <= 1'b0;
      synced_angle_trigger_r <= 1'b0;
    end else if (wr_in && hit(addr_in, `MCS_ADDR_GEN)) begin
      conversion_mode_select_r <= wdata_in[`MCS_GEN_MODE_BIT];
      angle_filter_enable_r <= wdata_in[`MCS_GEN_FILT_BIT];
      synced_angle_trigger_r <= wdata_in[`MCS_GEN_SYNC_BIT];
    end
  end

  // Pin functions power up as plain inputs.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pin_function_enable_r <= 2'h0;
    end else if (wr_in && hit(addr_in, `MCS_ADDR_PIN)) begin
      pin_function_enable_r <= wdata_in[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  assign seq_last = ang_cnt_r == 8'(ANG_PER_SEQ - 1);

  // Abort beats everything; a start is only honoured from idle.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_ev || boot_start_r) begin
          state_nxt = ST_TSENS;
        end
      end
      ST_TSENS: begin
        if (tsens_res_in.done) begin
          state_nxt = synced_angle_trigger_r && !conversion_mode_select_r ?
                      ST_SYNC : ST_ANGLE;
        end
      end
      ST_SYNC: begin
        if (pin_fall) begin
          state_nxt = ST_ANGLE;
        end
      end
      ST_ANGLE: begin
        if (angle_res_in.done) begin
          state_nxt = ST_CALC;
        end
      end
      ST_CALC: begin
        state_nxt = ST_STORE;
      end
      ST_STORE: begin
        if (!seq_last) begin
          state_nxt = synced_angle_trigger_r && !conversion_mode_select_r ?
                      ST_SYNC : ST_ANGLE;
        end else if (conversion_mode_select_r) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_TSENS;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (abort_ev) begin
      state_nxt = ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Measurement requests are single-cycle pulses on entering a phase.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      tsens_req_out <= 1'b0;
      angle_req_out <= 1'b0;
    end else begin
      tsens_req_out <= state_nxt == ST_TSENS && state_r != ST_TSENS;
      angle_req_out <= state_nxt == ST_ANGLE && state_r != ST_ANGLE;
    end
  end

  // Angle measurements counted within one sequence.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ang_cnt_r <= 8'h00;
    end else if (state_r == ST_TSENS || state_r == ST_IDLE) begin
      ang_cnt_r <= 8'h00;
    end else if (state_r == ST_STORE) begin
      ang_cnt_r <= ang_cnt_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Turn reference and cross-check.

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      first_seq_r <= 1'b1;
      load_ref_r <= 1'b0;
      tsens_turn_r <= 6'h00;
    end else begin
      if (state_r == ST_IDLE && state_nxt == ST_TSENS) begin
        first_seq_r <= 1'b1;
      end else if (state_r == ST_STORE && seq_last) begin
        first_seq_r <= 1'b0;
      end
      if (state_r == ST_TSENS && tsens_res_in.done) begin
        tsens_turn_r <= tsens_res_in.value[5:0];
        load_ref_r <= first_seq_r || conversion_mode_select_r;
      end else if (state_r == ST_ANGLE && angle_res_in.done) begin
        load_ref_r <= 1'b0;
      end
    end
  end

  assign xchk_hit = state_r == ST_TSENS && tsens_res_in.done &&
    !first_seq_r && !conversion_mode_select_r &&
    pos_dist({1'b0, tsens_res_in.value[5:0], track_pos.frac}, track_pos) >
    `MCS_HALF_TURN;

  // Sticky fault; a new mismatch wins over a write-one clear.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      xchk_fault_r <= 1'b0;
    end else if (xchk_hit) begin
      xchk_fault_r <= 1'b1;
    end else if (wr_in && hit(addr_in, `MCS_ADDR_FLT) &&
                 wdata_in[`MCS_FLT_XCHK_BIT]) begin
      xchk_fault_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Position processing.

  mcs_turn_tracker #(
    .ANGLE_W(`MCS_ANGLE_W)
  ) u_track (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .load_in(load_ref_r),
    .load_turn_in(tsens_turn_r),
    .sample_in(state_r == ST_ANGLE && angle_res_in.done),
    .angle_in(angle_res_in.value),
    .pos_out(track_pos)
  );

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      filt_restart_r <= 1'b1;
    end else if (state_r == ST_IDLE && state_nxt == ST_TSENS) begin
      filt_restart_r <= 1'b1;
    end else if (state_r == ST_CALC) begin
      filt_restart_r <= 1'b0;
    end
  end

  mcs_angle_filter #(
    .POS_W(`MCS_POS_W),
    .SHIFT(`MCS_FILT_SHIFT)
  ) u_filt (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .sample_in(state_r == ST_CALC),
    .restart_in(filt_restart_r),
    .enable_in(angle_filter_enable_r),
    .pos_in(track_pos),
    .pos_out(filt_pos)
  );

  assign filt_view = filt_pos;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      angle_reg_r <= '0;
      turn_reg_r <= '0;
    end else if (state_r == ST_STORE) begin
      angle_reg_r <= filt_view.frac;
      turn_reg_r <= filt_view.turn;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      turn_valid_r <= 1'b0;
    end else if (state_r == ST_STORE && seq_last) begin
      turn_valid_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Indications.

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= pin_function_enable_r[`MCS_PIN_BUSY_BIT] &&
                  state_nxt != ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      angle_calc_active_out <= 1'b0;
    end else begin
      angle_calc_active_out <= state_nxt == ST_CALC ||
                               state_nxt == ST_STORE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rdata_out <= `MCS_REG_RST;
    end else if (rd_in) begin
      rdata_out <= `MCS_REG_RST;
      if (hit(addr_in, `MCS_ADDR_CNV)) begin
        rdata_out[`MCS_CNV_HI:`MCS_CNV_LO] <= convert_field_r;
        rdata_out[`MCS_PAGE_W-1:0] <= page_r;
      end else if (hit(addr_in, `MCS_ADDR_GEN)) begin
        rdata_out[`MCS_GEN_MODE_BIT] <= conversion_mode_select_r;
        rdata_out[`MCS_GEN_FILT_BIT] <= angle_filter_enable_r;
        rdata_out[`MCS_GEN_SYNC_BIT] <= synced_angle_trigger_r;
      end else if (hit(addr_in, `MCS_ADDR_PIN)) begin
        rdata_out[1:0] <= pin_function_enable_r;
      end else if (hit(addr_in, `MCS_ADDR_FLT)) begin
        rdata_out[`MCS_FLT_XCHK_BIT] <= xchk_fault_r;
      end else if (hit(addr_in, `MCS_ADDR_ANG)) begin
        rdata_out[`MCS_ANGLE_W-1:0] <= angle_reg_r;
      end else if (hit(addr_in, `MCS_ADDR_TRN)) begin
        rdata_out[15] <= turn_valid_r;
        rdata_out[7:0] <= {turn_reg_r[`MCS_TURN_W-1], turn_reg_r};
      end else if (hit(addr_in, `MCS_ADDR_STS)) begin
        rdata_out[2:0] <= {state_r != ST_IDLE, busy_out,
                           angle_calc_active_out};
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/mcs_turn_tracker.sv
// Angle-derived turn counter with end-stop wrapping.
`include "mcs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mcs_turn_tracker #(
  parameter int ANGLE_W = `MCS_ANGLE_W
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [5:0] load_turn_in,
  input wire logic sample_in,
  input wire logic [ANGLE_W-1:0] angle_in,
  output mcs_pkg::mcs_pos_type pos_out
);
  import mcs_pkg::*;

  logic [1:0] old_q;
  logic [1:0] new_q;
  logic wrap_up;
  logic wrap_dn;

  // Quadrant crossing between samples tells the direction of a full turn.
  assign old_q = pos_out.frac[ANGLE_W-1 -: 2];
  assign new_q = angle_in[ANGLE_W-1 -: 2];
  assign wrap_up = (old_q == 2'h3) && (new_q == 2'h0);
  assign wrap_dn = (old_q == 2'h0) && (new_q == 2'h3);

  // The count is bounded; at the limits the position cycles in one turn.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pos_out <= '0;
    end else if (sample_in) begin
      pos_out.frac <= angle_in;
      if (load_in) begin
        pos_out.turn <= {1'b0, load_turn_in};
      end else if (wrap_up && pos_out.turn != `MCS_TURN_MAX) begin
        pos_out.turn <= pos_out.turn + 7'h01;
      end else if (wrap_dn && pos_out.turn != `MCS_TURN_MIN) begin
        pos_out.turn <= pos_out.turn - 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- shared/mcs_cfg.svh
// Register offsets, field positions, reset values and limits of the sequencer.
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
`define MCS_ADDR_W 4
`define MCS_DATA_W 16
`define MCS_ADDR_CNV 4'h0
`define MCS_ADDR_GEN 4'h1
`define MCS_ADDR_PIN 4'h2
`define MCS_ADDR_FLT 4'h3
`define MCS_ADDR_ANG 4'h4
`define MCS_ADDR_TRN 4'h5
`define MCS_ADDR_STS 4'h6
`define MCS_CNV_HI 15
`define MCS_CNV_LO 14
`define MCS_CNV_ABORT 2'h3
`define MCS_CNV_START 2'h0
`define MCS_PAGE_W 6
`define MCS_GEN_MODE_BIT 0
`define MCS_GEN_FILT_BIT 12
`define MCS_GEN_SYNC_BIT 13
`define MCS_PIN_BUSY_BIT 0
`define MCS_PIN_CNV_BIT 1
`define MCS_FLT_XCHK_BIT 13
`define MCS_REG_RST 16'h0000
`define MCS_ANGLE_W 12
`define MCS_TURN_W 7
`define MCS_POS_W 19
`define MCS_TURN_MAX 7'h36
`define MCS_TURN_MIN 7'h77
`define MCS_HALF_TURN 19'h0_0800
`define MCS_HI_OFF 19'h3_5800
`define MCS_HI_ON 19'h3_5000
`define MCS_LO_OFF 19'h7_7800
`define MCS_LO_ON 19'h7_8000
`define MCS_ANG_PER_SEQ 4
`define MCS_FILT_SHIFT 4
`endif

//--- shared/mcs_pkg.sv
// Types shared by the conversion sequencer and its helpers.
package mcs_pkg;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TSENS = 3'b001,
    ST_SYNC = 3'b010,
    ST_ANGLE = 3'b011,
    ST_CALC = 3'b100,
    ST_STORE = 3'b101
  } mcs_state_type;

  // Absolute position: signed whole turns above a fraction of a turn.
  typedef struct packed {
    logic [6:0] turn;
    logic [11:0] frac;
  } mcs_pos_type;

  // Result handed back by a sensor measurement.
  typedef struct packed {
    logic done;
    logic [11:0] value;
  } mcs_meas_type;
endpackage

//--- tb/mcs_checker.sv
// Port-level assertions for the conversion sequencer.
`timescale 1ns/1ns
`default_nettype none
module mcs_checker (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic convert_start_pin_in,
  input wire mcs_pkg::mcs_meas_type angle_res_in,
  input wire logic tsens_req_out,
  input wire logic angle_req_out,
  input wire logic busy_out,
  input wire logic angle_calc_active_out
);
  import mcs_pkg::*;
  logic pin_cnv_r, pin_busy_r, one_shot_r, pin_q_r, stopped_r, start_r;
  logic cnv_wr, abort_ev, start_ev;
  // Start and abort events as the host causes them, by pin or by field.
  assign cnv_wr = wr_in && addr_in == 4'h0;
  assign abort_ev = pin_cnv_r ? (convert_start_pin_in && !pin_q_r)
                              : (cnv_wr && wdata_in[15:14] == 2'h3);
  assign start_ev = pin_cnv_r ? (!convert_start_pin_in && pin_q_r)
                              : (cnv_wr && wdata_in[15:14] == 2'h0);
  // Shadow of the configuration bits that the assertions depend on.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      pin_cnv_r <= 1'b0;
      pin_busy_r <= 1'b0;
      one_shot_r <= 1'b0;
      pin_q_r <= 1'b0;
    end else begin
      pin_q_r <= convert_start_pin_in;
      if (wr_in && addr_in == 4'h2) begin
        pin_cnv_r <= wdata_in[1];
        pin_busy_r <= wdata_in[0];
      end
      if (wr_in && addr_in == 4'h1) one_shot_r <= wdata_in[0];
    end
  end
  // Stopped and start-pending flags; a stale start clears on the next request.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      stopped_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      if (abort_ev) stopped_r <= 1'b1;
      else if (tsens_req_out) stopped_r <= 1'b0;
      if (start_ev) start_r <= 1'b1;
      else if (tsens_req_out) start_r <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  a_boot_start: assert property ($rose(resetn_in) |-> ##[1:4] tsens_req_out)
    else $error("no turn request after reset");
  a_req_single: assert property (tsens_req_out |=> !tsens_req_out)
    else $error("turn request longer than one cycle");
  a_calc_width: assert property ($rose(angle_calc_active_out) |=>
    angle_calc_active_out ##1 !angle_calc_active_out)
    else $error("angle calc not two cycles");
  a_calc_cause: assert property ($rose(angle_calc_active_out) |->
    $past(angle_res_in.done) || $past(angle_res_in.done, 2))
    else $error("angle calc without a measurement");
  a_abort_quiet: assert property (abort_ev ##1 (!start_ev) [*4] |->
    (!busy_out && !angle_req_out) [*2])
    else $error("activity after abort");
  a_restart_cause: assert property (stopped_r && tsens_req_out |-> start_r)
    else $error("restart without a start event");
  a_field_locked: assert property (cnv_wr && pin_cnv_r && busy_out |=>
    busy_out [*4])
    else $error("convert field acted while pin owns it");
  a_busy_gate: assert property (!pin_busy_r && !$past(pin_busy_r) |->
    !busy_out)
    else $error("busy shown while disabled");
  a_oneshot_end: assert property ($fell(busy_out) && one_shot_r |->
    $past(angle_calc_active_out) || $past(angle_calc_active_out, 2) ||
    $past(angle_calc_active_out, 3))
    else $error("one-shot busy fell before angle store");
  c_abort: cover property (abort_ev);
  c_restart: cover property (stopped_r && tsens_req_out);
  c_oneshot: cover property ($fell(busy_out) && one_shot_r);
endmodule
bind mcs_conv_seq mcs_checker u_chk (.sys_clk_in(sys_clk_in),
  .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .convert_start_pin_in(convert_start_pin_in),
  .angle_res_in(angle_res_in), .tsens_req_out(tsens_req_out),
  .angle_req_out(angle_req_out), .busy_out(busy_out),
  .angle_calc_active_out(angle_calc_active_out));
`default_nettype wire

//--- tb/mcs_sensor_model.sv
// Behavioural turn and angle sensors answering the sequencer's requests.
`timescale 1ns/1ns
`default_nettype none
module mcs_sensor_model (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic tsens_req_in,
  input wire logic angle_req_in,
  input wire logic [3:0] delay_in,
  input wire logic [5:0] turns_in,
  input wire logic [11:0] angle_in,
  input wire logic [11:0] step_in,
  output mcs_pkg::mcs_meas_type tsens_res_out,
  output mcs_pkg::mcs_meas_type angle_res_out
);
  import mcs_pkg::*;
  logic [4:0] t_cnt_r, a_cnt_r;
  logic [11:0] ang_r;
  logic t_done, a_done;
  // Each request is answered after delay_in extra cycles, prompt or slow.
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      t_cnt_r <= 5'h0;
      a_cnt_r <= 5'h0;
    end else begin
      if (tsens_req_in) t_cnt_r <= {1'b0, delay_in} + 5'h1;
      else if (t_cnt_r != 5'h0) t_cnt_r <= t_cnt_r - 5'h1;
      if (angle_req_in) a_cnt_r <= {1'b0, delay_in} + 5'h1;
      else if (a_cnt_r != 5'h0) a_cnt_r <= a_cnt_r - 5'h1;
    end
  end
  // A still magnet follows angle_in; a turning one steps after each answer.
  always_ff @(posedge sys_clk_in) begin
    if (step_in == 12'h000) ang_r <= angle_in;
    else if (a_done) ang_r <= ang_r + step_in;
  end
  assign t_done = t_cnt_r == 5'h1;
  assign a_done = a_cnt_r == 5'h1;
  // Outside the answer cycle the values are inverted, so no hold is trusted.
  assign tsens_res_out = {t_done, t_done ? {6'h0, turns_in} : ~{6'h0, turns_in}};
  assign angle_res_out = {a_done, a_done ? ang_r : ~ang_r};
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mcs_pkg::*;
  logic clk, resetn, wr, rd, pin, busy, calc, treq, areq;
  logic [3:0] addr, dly;
  logic [15:0] wdata, rdata;
  logic [5:0] turns;
  logic [11:0] ang, step;
  mcs_meas_type tres, ares;
  int n_errors = 0;
  int samples_checked = 0;
  mcs_conv_seq dut (.sys_clk_in(clk), .resetn_in(resetn), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .convert_start_pin_in(pin), .tsens_res_in(tres), .angle_res_in(ares),
    .tsens_req_out(treq), .angle_req_out(areq), .busy_out(busy),
    .angle_calc_active_out(calc));
  mcs_sensor_model u_sens (.sys_clk_in(clk), .resetn_in(resetn),
    .tsens_req_in(treq), .angle_req_in(areq), .delay_in(dly),
    .turns_in(turns), .angle_in(ang), .step_in(step),
    .tsens_res_out(tres), .angle_res_out(ares));
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle write strobe; a gap cycle follows so strobes never merge.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand from the cycle after the strobe and hold until the next read.
  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  // Watch a fixed span for any turn request.
  task automatic watch(input int cy, input logic e);
    logic s;
    s = 1'b0;
    // A request launched by the edge that ended the last strobe counts too.
    #1 s = treq;
    repeat (cy) begin
      @(posedge clk);
      #1 s = s | treq;
    end
    chk("turn request", {15'h0, e}, {15'h0, s});
  endtask
  // Count finished angle calculations, bounded against a hang.
  task automatic calcs(input int n);
    int c, t;
    logic q;
    c = 0;
    t = 0;
    q = calc;
    while (c < n && t < n * 60) begin
      @(posedge clk);
      #1 t++;
      if (q && !calc) c++;
      q = calc;
    end
    chk("calc count", n[15:0], c[15:0]);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    pin = 1'b0;
    dly = 4'h0;
    turns = 6'd10;
    ang = 12'h100;
    step = 12'h000;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    watch(4, 1'b1);
    calcs(6);
    rd_chk("general", 4'h1, 16'h0000);
    rd_chk("turn", 4'h5, 16'h800A);
    rd_chk("angle", 4'h4, 16'h0100);
    rd_chk("unmapped", 4'hF, 16'h0000);
    $display("test boot done");
    dly <= 4'h4;
    wr_reg(4'h2, 16'h0001);
    calcs(1);
    chk("busy on", 16'h1, {15'h0, busy});
    wr_reg(4'h0, 16'hC000);
    watch(20, 1'b0);
    chk("busy off", 16'h0, {15'h0, busy});
    rd_chk("status", 4'h6, 16'h0000);
    wr_reg(4'h0, 16'h0000);
    watch(4, 1'b1);
    $display("test field control done");
    wr_reg(4'h2, 16'h0003);
    wr_reg(4'h0, 16'hC000);
    calcs(1);
    chk("busy kept", 16'h1, {15'h0, busy});
    pin <= 1'b1;
    watch(20, 1'b0);
    wr_reg(4'h0, 16'h0000);
    watch(20, 1'b0);
    pin <= 1'b0;
    watch(6, 1'b1);
    calcs(2);
    pin <= 1'b1;
    watch(20, 1'b0);
    wr_reg(4'h2, 16'h0001);
    $display("test pin control done");
    wr_reg(4'h1, 16'h1000);
    wr_reg(4'h0, 16'h0000);
    calcs(1);
    ang <= 12'h200;
    rd_chk("first filtered", 4'h4, 16'h0100);
    calcs(1);
    rd_chk("filter step", 4'h4, 16'h0110);
    turns <= 6'd12;
    calcs(9);
    rd_chk("cross fault", 4'h3, 16'h2000);
    $display("test filter done");
    wr_reg(4'h0, 16'hC000);
    wr_reg(4'h3, 16'h2000);
    wr_reg(4'h1, 16'h0001);
    turns <= 6'd20;
    wr_reg(4'h0, 16'h0000);
    calcs(4);
    watch(20, 1'b0);
    chk("idle busy", 16'h0, {15'h0, busy});
    rd_chk("one-shot turn", 4'h5, 16'h8014);
    rd_chk("one-shot fault", 4'h3, 16'h0000);
    turns <= 6'd21;
    wr_reg(4'h0, 16'h0000);
    calcs(4);
    rd_chk("turn reload", 4'h5, 16'h8015);
    $display("test one-shot done");
    wr_reg(4'h0, 16'hC000);
    wr_reg(4'h1, 16'h0000);
    turns <= 6'd46;
    step <= 12'h400;
    wr_reg(4'h0, 16'h0000);
    calcs(48);
    rd_chk("upper stop", 4'h5, 16'h8036);
    step <= 12'hC00;
    calcs(280);
    rd_chk("lower stop", 4'h5, 16'h80F7);
    $display("test end stops done");
    wrap_up();
  end
  // Watchdog well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule
`default_nettype wire
